/* src/tap_defs.vh */
// Constants shared by the boundary scan test port and its input synchroniser.
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

// Instruction register geometry and instruction codes.
`define IR_WIDTH 3
`define IR_CAPTURE 3'h1
`define INSTR_EXTEST 3'h0
`define INSTR_IDCODE 3'h1
`define INSTR_SAMPLE_Z 3'h2
`define INSTR_RSVD_A 3'h3
`define INSTR_SAMPLE_PRELOAD 3'h4
`define INSTR_RSVD_B 3'h5
`define INSTR_RSVD_C 3'h6
`define INSTR_BYPASS 3'h7

// Data register geometry.
`define ID_WIDTH 32
`define BSR_LEN 48
`define BSR_OE_CELL 47

// Data register selector codes.
`define SEL_BSR 2'h0
`define SEL_ID 2'h1
`define SEL_BYP 2'h2

// Input synchroniser layout: bit order of the sampled test pins.
`define PIN_COUNT 3
`define PIN_TCK 0
`define PIN_TMS 1
`define PIN_TDI 2
`define PIN_RESET 3'h6

`define STATE_WIDTH 4

`endif

/* src/tap_sync.v */
// Two-flop synchroniser for the test pins entering the reference clock domain.
`include "tap_defs.vh"

module tap_sync #(
    parameter WIDTH = `PIN_COUNT,
    parameter [WIDTH-1:0] RESET_VALUE = `PIN_RESET
) (
    input wire clk_in,
    input wire srst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    // The first stage feeds only the second; nothing else may look at it.
    always @(posedge clk_in) begin
        if (srst_in) begin
            stage1 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* src/boundary_scan_tap.v */
// Boundary scan test access port: controller, instruction and data registers.
`include "tap_defs.vh"

// Functional notes
// R01: Sample TMS and TDI on TCK rise.
// R02: TDO changes only on TCK fall.
// R03: Unconnected TMS and TDI read as high.
// R04: Shift in at MSB, out at LSB.
// R05: Five TMS-high rising edges reset the port.
// R06: Port reset leaves memory operation undisturbed.
// R07: Power-up reset leaves TDO high impedance.
// R08: Instruction selects exactly one data register.
// R09: Three-bit instruction, five used, three reserved.
// R10: Reset loads the identification instruction.
// R11: Capture-IR loads binary 01 into low bits.
// R12: New instruction takes effect at Update-IR.
// R13: One-bit bypass, cleared when bypass executes.
// R14: Boundary register captures and shifts pin ring.
// R15: EXTEST, SAMPLE/PRELOAD, SAMPLE Z capture the ring.
// R16: IDCODE captures and shifts 32-bit identity.
// R17: SAMPLE Z floats output bus until Update-IR.
// R18: TDO driven only in shift states.
// R19: Bypass instruction puts bypass bit in path.
// R20: EXTEST drives preloaded cells to output pins.
// R21: Cell 47 gates output bus under EXTEST.
// R22: Output-enable cell presets high in reset.
// R23: Standard sixteen-state controller driven by TMS.
module boundary_scan_tap #(
    // Identity value is arbitrary; bit 0 is one as the scan convention asks.
    parameter [`ID_WIDTH-1:0] ID_VALUE = 32'h1234_5001
) (
    input wire REF_CLK_IN,
    input wire SRST_IN,
    input wire TCK_IN,
    input wire TMS_IN,
    input wire TDI_IN,
    output reg TDO_OUT,
    output reg TDO_OE_OUT,
    input wire [`BSR_LEN-1:0] RING_CAPTURE_IN,
    input wire SYS_OBUS_OE_IN,
    output reg [`BSR_LEN-1:0] RING_DRIVE_OUT,
    output reg EXTEST_ACTIVE_OUT,
    output reg OBUS_OE_OUT,
    output reg [`STATE_WIDTH-1:0] TAP_STATE_OUT,
    output reg [`IR_WIDTH-1:0] INSTR_OUT
);

    localparam [`STATE_WIDTH-1:0] ST_RESET = 4'h0;
    localparam [`STATE_WIDTH-1:0] ST_IDLE = 4'h1;
    localparam [`STATE_WIDTH-1:0] ST_SEL_DR = 4'h2;
    localparam [`STATE_WIDTH-1:0] ST_CAP_DR = 4'h3;
    localparam [`STATE_WIDTH-1:0] ST_SHIFT_DR = 4'h4;
    localparam [`STATE_WIDTH-1:0] ST_EXIT1_DR = 4'h5;
    localparam [`STATE_WIDTH-1:0] ST_PAUSE_DR = 4'h6;
    localparam [`STATE_WIDTH-1:0] ST_EXIT2_DR = 4'h7;
    localparam [`STATE_WIDTH-1:0] ST_UPD_DR = 4'h8;
    localparam [`STATE_WIDTH-1:0] ST_SEL_IR = 4'h9;
    localparam [`STATE_WIDTH-1:0] ST_CAP_IR = 4'hA;
    localparam [`STATE_WIDTH-1:0] ST_SHIFT_IR = 4'hB;
    localparam [`STATE_WIDTH-1:0] ST_EXIT1_IR = 4'hC;
    localparam [`STATE_WIDTH-1:0] ST_PAUSE_IR = 4'hD;
    localparam [`STATE_WIDTH-1:0] ST_EXIT2_IR = 4'hE;
    localparam [`STATE_WIDTH-1:0] ST_UPD_IR = 4'hF;

    // Picks the data register for an instruction; reserved codes fall back to bypass.
    function [1:0] select_of;
        input [`IR_WIDTH-1:0] instr;
        begin
            case (instr)
                `INSTR_EXTEST: select_of = `SEL_BSR;
                `INSTR_SAMPLE_PRELOAD: select_of = `SEL_BSR;
                `INSTR_SAMPLE_Z: select_of = `SEL_BSR;
                `INSTR_IDCODE: select_of = `SEL_ID;
                default: select_of = `SEL_BYP; // R09
            endcase
        end
    endfunction

    wire [`PIN_COUNT-1:0] pins_sync;
    reg tck_prev;
    wire tck_now;
    wire tms;
    wire tdi;
    wire tck_rise;
    wire tck_fall;
    wire enter_reset;
    wire extest_now;
    wire shift_state;

    reg [`STATE_WIDTH-1:0] state;
    reg [`STATE_WIDTH-1:0] next_state;
    reg [`IR_WIDTH-1:0] ir_shift;
    reg [`IR_WIDTH-1:0] instr;
    reg bypass;
    reg [`ID_WIDTH-1:0] id_shift;
    reg [`BSR_LEN-1:0] bsr_shift;
    reg [`BSR_LEN-1:0] bsr_update;
    wire [1:0] dr_select;
    reg serial_bit;

    // Test pins cross into the reference domain; reset value keeps TMS and TDI high.
    // A floating pin cannot be seen from inside, so the pull-ups exist here only as
    // this reset value; on a board the pins still need their pull-ups.
    tap_sync #(
        .WIDTH(`PIN_COUNT),
        .RESET_VALUE(`PIN_RESET)
    ) u_pin_sync (
        .clk_in(REF_CLK_IN),
        .srst_in(SRST_IN),
        .async_in({TDI_IN, TMS_IN, TCK_IN}),
        .sync_out(pins_sync)
    ); // R03

    assign tck_now = pins_sync[`PIN_TCK];
    assign tms = pins_sync[`PIN_TMS];
    assign tdi = pins_sync[`PIN_TDI];

    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= tck_now;
        end
    end

    // TMS and TDI are synchronised with TCK, so they are stable at its rise.
    assign tck_rise = tck_now & ~tck_prev; // R01
    assign tck_fall = ~tck_now & tck_prev; // R02

    assign dr_select = select_of(instr); // R08
    assign extest_now = (instr == `INSTR_EXTEST);
    assign shift_state = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);

    // The rise that leads into Test-Logic-Reset restores the reset contents at once,
    // so the old instruction never acts inside the reset state.
    assign enter_reset = tck_rise && (next_state == ST_RESET); // R05

    // Sixteen-state controller; five TMS-high rises reach reset from anywhere.
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE; // R05
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            state <= ST_RESET; // R07
        end else if (tck_rise) begin
            state <= next_state; // R23
        end
    end

    // Instruction shift path: capture pattern first, then shift toward TDO.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            ir_shift <= `IR_CAPTURE;
        end else if (tck_rise) begin
            if (state == ST_CAP_IR) begin
                ir_shift <= `IR_CAPTURE; // R11
            end else if (state == ST_SHIFT_IR) begin
                ir_shift <= {tdi, ir_shift[`IR_WIDTH-1:1]}; // R04
            end
        end
    end

    // The applied instruction moves only at Update-IR and on entry to reset; a shift that is abandoned
    // through reset never reaches it.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            instr <= `INSTR_IDCODE; // R10
        end else if (enter_reset) begin
            instr <= `INSTR_IDCODE; // R10
        end else if (tck_rise && state == ST_UPD_IR) begin
            instr <= ir_shift; // R12
        end
    end

    // Bypass bit: zero on capture and whenever the bypass instruction is applied.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            bypass <= 1'b0;
        end else if (tck_rise) begin
            if (state == ST_UPD_IR && select_of(ir_shift) == `SEL_BYP) begin
                bypass <= 1'b0; // R13
            end else if (dr_select == `SEL_BYP) begin
                if (state == ST_CAP_DR) begin
                    bypass <= 1'b0; // R13
                end else if (state == ST_SHIFT_DR) begin
                    bypass <= tdi; // R19
                end
            end
        end
    end

    // Identity register: hardwired value loaded at capture, shifted toward TDO.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            id_shift <= ID_VALUE;
        end else if (tck_rise && dr_select == `SEL_ID) begin
            if (state == ST_CAP_DR) begin
                id_shift <= ID_VALUE; // R16
            end else if (state == ST_SHIFT_DR) begin
                id_shift <= {tdi, id_shift[`ID_WIDTH-1:1]}; // R16
            end
        end
    end

    // Boundary register: the ring is snapshot at capture; a changing pin may be
    // caught mid-transition, which is harmless but not repeatable.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            bsr_shift <= {`BSR_LEN{1'b0}};
        end else if (tck_rise && dr_select == `SEL_BSR) begin
            if (state == ST_CAP_DR) begin
                bsr_shift <= RING_CAPTURE_IN; // R15
            end else if (state == ST_SHIFT_DR) begin
                bsr_shift <= {tdi, bsr_shift[`BSR_LEN-1:1]}; // R14
            end
        end
    end

    // Preload latches; the output-enable cell is forced high while in reset.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            bsr_update <= {`BSR_LEN{1'b0}};
            bsr_update[`BSR_OE_CELL] <= 1'b1; // R22
        end else if (tck_rise) begin
            if (next_state == ST_RESET) begin
                bsr_update[`BSR_OE_CELL] <= 1'b1; // R22
            end else if (state == ST_UPD_DR && (instr == `INSTR_EXTEST
                    || instr == `INSTR_SAMPLE_PRELOAD)) begin
                bsr_update <= bsr_shift; // R21
            end
        end
    end

    always @* begin
        case (dr_select)
            `SEL_ID: serial_bit = id_shift[0];
            `SEL_BSR: serial_bit = bsr_shift[0];
            default: serial_bit = bypass;
        endcase
        if (state == ST_SHIFT_IR) begin
            serial_bit = ir_shift[0]; // R04
        end
    end

    // TDO and its enable move only on TCK fall, half a test cycle after the shift.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            TDO_OUT <= 1'b0;
            TDO_OE_OUT <= 1'b0; // R07
        end else if (tck_fall) begin
            TDO_OUT <= serial_bit; // R02
            TDO_OE_OUT <= shift_state; // R18
        end
    end

    // Controller status, copied out one reference cycle late for observation.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            TAP_STATE_OUT <= ST_RESET;
            INSTR_OUT <= `INSTR_IDCODE;
        end else begin
            TAP_STATE_OUT <= state;
            INSTR_OUT <= instr;
        end
    end

    // Memory-facing controls; outside EXTEST and SAMPLE Z the memory runs untouched.
    always @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            RING_DRIVE_OUT <= {`BSR_LEN{1'b0}};
            EXTEST_ACTIVE_OUT <= 1'b0;
            OBUS_OE_OUT <= 1'b0;
        end else begin
            RING_DRIVE_OUT <= bsr_update; // R20
            EXTEST_ACTIVE_OUT <= extest_now; // R20
            if (extest_now) begin
                OBUS_OE_OUT <= bsr_update[`BSR_OE_CELL]; // R21
            end else if (instr == `INSTR_SAMPLE_Z) begin
                OBUS_OE_OUT <= 1'b0; // R17
            end else begin
                OBUS_OE_OUT <= SYS_OBUS_OE_IN; // R06
            end
        end
    end

endmodule

/* tb/tap_props.sv */
// Concurrent checks on the pins of the boundary scan test port.
`include "tap_defs.vh"
module tap_props (
    input wire REF_CLK_IN,
    input wire SRST_IN,
    input wire TCK_IN,
    input wire TMS_IN,
    input wire TDO_OUT,
    input wire TDO_OE_OUT,
    input wire [`BSR_LEN-1:0] RING_DRIVE_OUT,
    input wire EXTEST_ACTIVE_OUT,
    input wire OBUS_OE_OUT,
    input wire [`STATE_WIDTH-1:0] TAP_STATE_OUT,
    input wire [`IR_WIDTH-1:0] INSTR_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);
    // Counts test clock rises seen with mode select high; it saturates so it rises once.
    reg tck_d;
    reg [2:0] ones;
    always @(posedge REF_CLK_IN) begin
        tck_d <= TCK_IN;
        if (SRST_IN) ones <= 3'h0;
        else if (TCK_IN && !tck_d) ones <= TMS_IN ? (ones == 3'h5 ? ones : ones + 3'h1) : 3'h0;
    end
    sequence s_five;
        $rose(ones == 3'h5);
    endsequence
    sequence s_ir_shift;
        $rose(TDO_OE_OUT) && TAP_STATE_OUT == 4'hB;
    endsequence
    property p_oe_shift;
        TDO_OE_OUT |-> TAP_STATE_OUT inside {4'h4, 4'h5, 4'hB, 4'hC};
    endproperty
    property p_tdo_fall;
        $changed(TDO_OUT) |-> !$past(TCK_IN, 1) && !$past(TCK_IN, 2);
    endproperty
    property p_capir;
        s_ir_shift |-> TDO_OUT;
    endproperty
    property p_five;
        s_five |-> ##[1:8] TAP_STATE_OUT == 4'h0;
    endproperty
    property p_rst_id;
        (TAP_STATE_OUT == 4'h0) [*2] |-> INSTR_OUT == `INSTR_IDCODE;
    endproperty
    property p_instr_upd;
        $changed(INSTR_OUT) |-> TAP_STATE_OUT inside {4'h0, 4'h1, 4'h2, 4'hF};
    endproperty
    property p_obus_ext;
        EXTEST_ACTIVE_OUT [*2] |-> OBUS_OE_OUT == RING_DRIVE_OUT[`BSR_OE_CELL];
    endproperty
    property p_samplez;
        (INSTR_OUT == `INSTR_SAMPLE_Z) [*2] |-> !OBUS_OE_OUT;
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("TDO driven outside shift");
    a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved with TCK high");
    a_capir: assert property (p_capir) else $error("capture pattern bit 0 not one");
    a_five: assert property (p_five) else $error("five TMS ones did not reset");
    a_rst_id: assert property (p_rst_id) else $error("reset state without IDCODE");
    a_instr_upd: assert property (p_instr_upd) else $error("instruction moved early");
    a_obus_ext: assert property (p_obus_ext) else $error("bus enable not cell 47");
    a_samplez: assert property (p_samplez) else $error("bus driven in SAMPLE Z");
endmodule

bind boundary_scan_tap tap_props u_props (.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN),
    .TCK_IN(TCK_IN), .TMS_IN(TMS_IN), .TDO_OUT(TDO_OUT), .TDO_OE_OUT(TDO_OE_OUT),
    .RING_DRIVE_OUT(RING_DRIVE_OUT), .EXTEST_ACTIVE_OUT(EXTEST_ACTIVE_OUT),
    .OBUS_OE_OUT(OBUS_OE_OUT), .TAP_STATE_OUT(TAP_STATE_OUT), .INSTR_OUT(INSTR_OUT));

/* tb/tap_host.sv */
// Model of the external scan controller driving the four-wire test link.
module tap_host (
    input wire clk_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire tdo_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end
    // One 160 ns test clock period; mode and data move with the fall so they are
    // held four reference cycles either side of the rise; between frames the clock
    // rests high.
    task step(input tms, input tdi, output tdo);
        tck_out <= 1'b0;
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (4) @(posedge clk_in);
        tck_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        tdo = tdo_in;
    endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the boundary scan test port.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Identity value is arbitrary.
    localparam [31:0] ID_EXP = 32'hC0DE_0A01;
    logic clk;
    logic srst = 1'b1;
    logic [47:0] ring = 48'h0;
    logic sys_oe = 1'b0;
    logic [31:0] lfsr = 32'h0000_01C2;
    logic [63:0] din = 64'h0;
    logic [63:0] dout;
    logic [2:0] code;
    logic b;
    integer n_mismatch = 0;
    integer n_compared = 0;
    integer k;
    wire tck, tms, tdi, tdo, tdo_oe, ext, obus, tdo_w;
    wire [47:0] drive;
    wire [3:0] state;
    wire [2:0] instr;
    assign tdo_w = tdo_oe ? tdo : 1'bz;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    tap_host host (.clk_in(clk), .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_w));
    boundary_scan_tap #(.ID_VALUE(ID_EXP)) DUT (.REF_CLK_IN(clk), .SRST_IN(srst),
        .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe),
        .RING_CAPTURE_IN(ring), .SYS_OBUS_OE_IN(sys_oe), .RING_DRIVE_OUT(drive),
        .EXTEST_ACTIVE_OUT(ext), .OBUS_OE_OUT(obus), .TAP_STATE_OUT(state),
        .INSTR_OUT(instr));
    function automatic [31:0] rnd(input [31:0] s);
        rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // A 64-bit scan returns the captured register, LSB first, then the data sent in.
    function automatic [63:0] dr_expect(input [2:0] c, input [47:0] cap, input [63:0] d);
        integer i;
        integer n;
        reg [47:0] v;
        n = (c == 3'h0 || c == 3'h2 || c == 3'h4) ? 48 : (c == 3'h1 ? 32 : 1);
        v = (n == 48) ? cap : (n == 32 ? {16'h0, ID_EXP} : 48'h0);
        for (i = 0; i < 64; i = i + 1) dr_expect[i] = (i < n) ? v[i] : d[i - n];
    endfunction
    task check(input [63:0] got_v, input [63:0] exp_v);
        n_compared = n_compared + 1;
        if (got_v !== exp_v) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask
    task test_done;
        $display("Counts: compared=%0d mismatch=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task scan(input ir, input integer n);
        integer i;
        host.step(1'b1, 1'b1, b);
        if (ir) host.step(1'b1, 1'b1, b);
        host.step(1'b0, 1'b1, b);
        host.step(1'b0, 1'b1, b);
        for (i = 0; i < n; i = i + 1) begin
            host.step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        host.step(1'b1, 1'b1, b);
        host.step(1'b0, 1'b1, b);
        repeat (4) @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        test_done;
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        check(instr, 3'h1);
        check(tdo_oe, 1'b0);
        check(drive, 48'h8000_0000_0000);
        host.step(1'b0, 1'b1, b);
        for (k = 0; k < 10; k = k + 1) begin
            code = k > 0 ? k[2:0] - 3'h1 : 3'h1;
            if (k > 0) begin
                din[2:0] = code;
                scan(1'b1, 3);
                check(dout[2:0], 3'h1);
                check(instr, code);
            end
            lfsr = rnd(lfsr);
            din[31:0] = lfsr;
            lfsr = rnd(lfsr);
            din[63:32] = lfsr;
            // The last pass is an external test with the bus enable cell cleared.
            if (k == 9) din[63] = 1'b0;
            ring <= {lfsr[15:0], din[31:0]};
            sys_oe <= lfsr[20];
            scan(1'b0, 64);
            check(dout, dr_expect(code, ring, din));
            if (code == 3'h0 || code == 3'h4) check(drive, din[63:16]);
            check(ext, code == 3'h0);
            if (code == 3'h0) check(obus, din[63]);
            else if (code == 3'h2) check(obus, 1'b0);
            else check(obus, sys_oe);
        end
        for (k = 0; k < 5; k = k + 1) host.step(1'b1, 1'b1, b);
        repeat (4) @(posedge clk);
        check(state, 4'h0);
        check(instr, 3'h1);
        check(drive[47], 1'b1);
        test_done;
    end
endmodule
